// file: src/bcc_ctrl.v
// Digital control of the magnetic boost converter feeding the LED drivers.
`timescale 1ns/100ps
`include "bcc_map.vh"

module bcc_ctrl #(
	parameter SS_CYC = `BCC_SOFT_START_CYC,
	parameter DUTY_PCT = `BCC_DUTY_MAX_PCT
) (
	// Clock and reset.
	input wire clk,
	input wire nrst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Analog comparator flags, asynchronous to clk.
	input wire fb_low_async,
	input wire ipk_trip_async,
	// Converter controls.
	output wire sw_gate,
	output reg [3:0] vout_step,
	output reg [2:0] freq_sel_oh,
	output reg pfm_mode,
	output reg pwm_mode,
	output reg active_load_en,
	output reg leds_blank,
	output reg [1:0] rgb_sel
);

	localparam PW = 9;
	// Cycle counts are worked out at full integer width and then cut to
	// the counter width on purpose; the longest period still fits.
	localparam PER_HI_N = `BCC_PER_HI_CYC;
	localparam PER_MID_N = `BCC_PER_MID_CYC;
	localparam PER_LO_N = `BCC_PER_LO_CYC;
	localparam MAX_HI_N = (PER_HI_N * DUTY_PCT) / 100;
	localparam MAX_MID_N = (PER_MID_N * DUTY_PCT) / 100;
	localparam MAX_LO_N = (PER_LO_N * DUTY_PCT) / 100;
	localparam [PW-1:0] PER_HI = PER_HI_N[PW-1:0];
	localparam [PW-1:0] PER_MID = PER_MID_N[PW-1:0];
	localparam [PW-1:0] PER_LO = PER_LO_N[PW-1:0];
	localparam [PW-1:0] MAX_HI = MAX_HI_N[PW-1:0];
	localparam [PW-1:0] MAX_MID = MAX_MID_N[PW-1:0];
	localparam [PW-1:0] MAX_LO = MAX_LO_N[PW-1:0];
	localparam [31:0] SS_LAST = SS_CYC - 1;

	// Sequencer states.
	localparam [2:0] ST_OFF = 3'b001;
	localparam [2:0] ST_SOFT = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;

	reg [7:0] enables_q;
	reg [7:0] vcode_q;
	reg [7:0] freq_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [31:0] ss_cnt_q;
	reg fb_meta_q;
	reg fb_sync_q;
	reg ipk_meta_q;
	reg ipk_sync_q;
	reg [PW-1:0] period_q;
	reg [PW-1:0] max_on_q;
	reg [3:0] step_d;
	reg [7:0] status_d;
	wire en_boost;
	wire en_autoload;
	wire cyc_start;
	integer i;

	assign en_boost = enables_q[`BCC_EN_BOOST_BIT];
	assign en_autoload = enables_q[`BCC_EN_AUTOLOAD_BIT];

	// Two-flop synchronisers for the analog comparator flags.
	// Only the second flop of each pair is read, so a metastable first
	// stage never reaches the pulse logic.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fb_meta_q <= 1'b0;
			fb_sync_q <= 1'b0;
			ipk_meta_q <= 1'b0;
			ipk_sync_q <= 1'b0;
		end else begin
			fb_meta_q <= fb_low_async;
			fb_sync_q <= fb_meta_q;
			ipk_meta_q <= ipk_trip_async;
			ipk_sync_q <= ipk_meta_q;
		end
	end

	// Register writes; unmapped addresses are ignored.
	// Spare enables bits are stored so software reads back what it wrote.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			enables_q <= `BCC_ENABLES_RST;
			vcode_q <= `BCC_VCODE_RST;
			freq_q <= `BCC_FREQ_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`BCC_ENABLES_ADDR: begin
					enables_q <= reg_wdata;
				end
				`BCC_VCODE_ADDR: begin
					vcode_q <= reg_wdata;
				end
				`BCC_FREQ_ADDR: begin
					freq_q <= reg_wdata;
				end
				default: begin
					enables_q <= enables_q;
				end
			endcase
		end
	end

	// Register reads are registered; unmapped reads return zero.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`BCC_ENABLES_ADDR: begin
					reg_rdata <= enables_q;
				end
				`BCC_VCODE_ADDR: begin
					reg_rdata <= vcode_q;
				end
				`BCC_FREQ_ADDR: begin
					reg_rdata <= freq_q;
				end
				`BCC_STATUS_ADDR: begin
					reg_rdata <= status_d;
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// Status bits are placed by the map, so the layout has one owner.
	always @* begin
		status_d = 8'h00;
		status_d[`BCC_ST_OFF_BIT] = (state_q == ST_OFF);
		status_d[`BCC_ST_SOFT_BIT] = (state_q == ST_SOFT);
		status_d[`BCC_ST_RUN_BIT] = (state_q == ST_RUN);
		status_d[`BCC_ST_GATE_BIT] = sw_gate;
	end

	// Highest set bit wins.
	// Scanning upward lets the top set bit overwrite lower ones, so any
	// code lands on one of the nine documented steps.
	always @* begin
		step_d = 4'h0;
		for (i = 0; i < 8; i = i + 1) begin
			if (vcode_q[i]) begin
				step_d = i[3:0] + 4'h1;
			end
		end
	end

	// The reset step matches the reset code, so no other target is
	// requested for a cycle after reset.
	// Nine-step target output.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vout_step <= `BCC_VSTEP_RST;
		end else begin
			vout_step <= step_d;
		end
	end

	// Priority frequency decode.
	// Code 000 is not listed; it falls to the lowest frequency as the
	// gentlest setting. Period changes take effect at a cycle boundary so
	// no runt switching period is produced.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			period_q <= PER_HI;
			max_on_q <= MAX_HI;
			freq_sel_oh <= `BCC_FSEL_OH_RST;
		end else if (cyc_start || state_q == ST_OFF) begin
			if (freq_q[`BCC_FSEL_HI]) begin
				period_q <= PER_HI;
				max_on_q <= MAX_HI;
				freq_sel_oh <= 3'b100;
			end else if (freq_q[`BCC_FSEL_HI-1]) begin
				period_q <= PER_MID;
				max_on_q <= MAX_MID;
				freq_sel_oh <= 3'b010;
			end else begin
				period_q <= PER_LO;
				max_on_q <= MAX_LO;
				freq_sel_oh <= 3'b001;
			end
		end
	end

	// Sequencer next state.
	// A disable during soft start drops straight to off, so a later
	// enable always restarts the full soft-start interval.
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (en_boost) begin
					state_d = ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (!en_boost) begin
					state_d = ST_OFF;
				end else if (ss_cnt_q >= SS_LAST) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!en_boost) begin
					state_d = ST_OFF;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	// State register and the soft-start timer.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_OFF;
			ss_cnt_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			if (state_q == ST_SOFT && state_d == ST_SOFT) begin
				ss_cnt_q <= ss_cnt_q + 32'h00000001;
			end else begin
				ss_cnt_q <= 32'h00000000;
			end
		end
	end

	// Mode outputs follow the next state so they change with state_q, one cycle before the gate.
	// The active load stays off while the converter is off, since there
	// is no excess charge to bleed and it would only waste current.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pfm_mode <= 1'b0;
			pwm_mode <= 1'b0;
			leds_blank <= 1'b0;
			active_load_en <= 1'b0;
			rgb_sel <= 2'b00;
		end else begin
			pfm_mode <= (state_d == ST_SOFT);
			pwm_mode <= (state_d == ST_RUN);
			leds_blank <= (state_d == ST_SOFT);
			active_load_en <= en_autoload & (state_d != ST_OFF);
			rgb_sel <= enables_q[`BCC_RGB_SEL_HI:`BCC_RGB_SEL_LO];
		end
	end

	// Pulse generator; PWM skipping is allowed only with the active load off,
	// since the load is what bleeds off the forced minimum pulses.
	bcc_pulse #(
		.PW(PW)
	) u_pulse (
		.clk(clk),
		.nrst(nrst),
		.run_en(state_q != ST_OFF),
		.pfm(state_q == ST_SOFT),
		.skip_ok(~en_autoload),
		.period(period_q),
		.max_on(max_on_q),
		.fb_low(fb_sync_q),
		.ipk_trip(ipk_sync_q),
		.sw_gate(sw_gate),
		.cyc_start(cyc_start)
	);

endmodule

// file: src/bcc_map.vh
// Register map, reset values and timing constants of the boost control.
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// Register addresses.
`define BCC_ENABLES_ADDR 8'h08
`define BCC_VCODE_ADDR 8'h0D
`define BCC_FREQ_ADDR 8'h0E
`define BCC_STATUS_ADDR 8'h0F

// Reset values.
`define BCC_ENABLES_RST 8'h00
`define BCC_VCODE_RST 8'h3F
`define BCC_FREQ_RST 8'h07
`define BCC_VSTEP_RST 4'h6
`define BCC_FSEL_OH_RST 3'h4

// Field positions in the enables register.
`define BCC_EN_BOOST_BIT 5
`define BCC_EN_AUTOLOAD_BIT 4
`define BCC_RGB_SEL_HI 7
`define BCC_RGB_SEL_LO 6

// Field positions in the frequency register.
`define BCC_FSEL_HI 2
`define BCC_FSEL_LO 0

// Status register fields.
`define BCC_ST_OFF_BIT 0
`define BCC_ST_SOFT_BIT 1
`define BCC_ST_RUN_BIT 2
`define BCC_ST_GATE_BIT 3

// Clock rate and time figures.
`define BCC_CLK_KHZ 250000
`define BCC_CLK_PS 4000
`define BCC_F_HI_KHZ 2000
`define BCC_F_MID_KHZ 1670
`define BCC_F_LO_KHZ 1000
`define BCC_MIN_PULSE_PS 25000
`define BCC_SOFT_START_MS 10
`define BCC_DUTY_MAX_PCT 85

// Derived cycle counts; a least time rounds up.
`define BCC_MIN_PULSE_CYC ((`BCC_MIN_PULSE_PS + `BCC_CLK_PS - 1) / `BCC_CLK_PS)
`define BCC_SOFT_START_CYC (`BCC_SOFT_START_MS * `BCC_CLK_KHZ)
`define BCC_PER_HI_CYC (`BCC_CLK_KHZ / `BCC_F_HI_KHZ)
`define BCC_PER_MID_CYC (`BCC_CLK_KHZ / `BCC_F_MID_KHZ)
`define BCC_PER_LO_CYC (`BCC_CLK_KHZ / `BCC_F_LO_KHZ)

`endif

// file: src/bcc_pulse.v
// Switch pulse generator with minimum width and duty limit.
`timescale 1ns/100ps
`include "bcc_map.vh"

module bcc_pulse #(
	parameter PW = 9,
	parameter MIN_CYC = `BCC_MIN_PULSE_CYC
) (
	// Clock and reset.
	input wire clk,
	input wire nrst,
	// Control from the sequencer.
	input wire run_en,
	input wire pfm,
	input wire skip_ok,
	input wire [PW-1:0] period,
	input wire [PW-1:0] max_on,
	// Synchronised analog flags.
	input wire fb_low,
	input wire ipk_trip,
	// Switch drive.
	output reg sw_gate,
	output reg cyc_start
);

	reg [PW-1:0] cnt_q;
	reg [PW-1:0] on_q;
	wire last;
	wire fire;
	wire stop;

	assign last = (cnt_q >= period - {{(PW-1){1'b0}}, 1'b1});

	// Skip at light load only in PFM or when skip_ok is set.
	// In PWM a pulse is fired every cycle unless skipping is allowed and
	// the output is already high; PFM fires only when the output sags.
	assign fire = pfm ? fb_low : (fb_low | ~skip_ok);

	// Digital duty limit.
	// The peak-current trip is ignored until the minimum width has passed,
	// so a noisy early trip can never shorten the pulse below it.
	assign stop = (on_q >= max_on - {{(PW-1){1'b0}}, 1'b1}) |
		(ipk_trip & (on_q >= MIN_CYC[PW-1:0] - {{(PW-1){1'b0}}, 1'b1}));

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= {PW{1'b0}};
			cyc_start <= 1'b0;
		end else if (!run_en) begin
			cnt_q <= {PW{1'b0}};
			cyc_start <= 1'b0;
		end else begin
			cnt_q <= last ? {PW{1'b0}} : cnt_q + {{(PW-1){1'b0}}, 1'b1};
			cyc_start <= last;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sw_gate <= 1'b0;
			on_q <= {PW{1'b0}};
		end else if (!run_en) begin
			sw_gate <= 1'b0;
			on_q <= {PW{1'b0}};
		end else if (cnt_q == {PW{1'b0}}) begin
			sw_gate <= fire;
			on_q <= {PW{1'b0}};
		end else if (sw_gate) begin
			sw_gate <= ~stop;
			on_q <= on_q + {{(PW-1){1'b0}}, 1'b1};
		end
	end

endmodule

// file: tb/bcc_ctrl_checker.sv
// Assertion checker for the boost control block.
`timescale 1ns/100ps
module bcc_ctrl_checker #(
	parameter SS_CYC = 50,
	parameter DUTY_PCT = 85
) (
	// Clock and reset.
	input wire clk,
	input wire nrst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	// Converter controls.
	input wire sw_gate,
	input wire [3:0] vout_step,
	input wire [2:0] freq_sel_oh,
	input wire pfm_mode,
	input wire pwm_mode,
	input wire active_load_en,
	input wire leds_blank
);
	// Longest pulse is the 1 MHz duty limit.
	localparam int MAXON = 250 * DUTY_PCT / 100;
	reg [21:0] ss_q;
	reg [8:0] hi_q;

	// Run lengths of soft start and of one gate pulse.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ss_q <= 22'h0;
			hi_q <= 9'h0;
		end else begin
			ss_q <= pfm_mode ? ss_q + 22'h1 : 22'h0;
			hi_q <= sw_gate ? hi_q + 9'h1 : 9'h0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_off;
		!pfm_mode && !pwm_mode && !sw_gate;
	endsequence
	sequence s_min;
		sw_gate [*7];
	endsequence

	property p_stop;
		reg_wr && reg_addr == 8'h08 && !reg_wdata[5] |-> ##[1:4] s_off;
	endproperty
	a_stop: assert property (p_stop) else $error("gate not stopped");
	property p_min;
		$rose(sw_gate) |-> s_min;
	endproperty
	a_min: assert property (p_min) else $error("pulse too short");
	property p_duty;
		hi_q <= MAXON;
	endproperty
	a_duty: assert property (p_duty) else $error("pulse too long");
	property p_ss;
		ss_q <= SS_CYC + 1;
	endproperty
	a_ss: assert property (p_ss) else $error("soft start too long");
	property p_pwm;
		$rose(pwm_mode) |-> $past(pfm_mode);
	endproperty
	a_pwm: assert property (p_pwm) else $error("run without soft");
	property p_blank;
		leds_blank == pfm_mode;
	endproperty
	a_blank: assert property (p_blank) else $error("leds lit");
	property p_vmax;
		reg_wr && reg_addr == 8'h0D && reg_wdata == 8'hFF
			|-> ##[1:2] vout_step == 4'h8;
	endproperty
	a_vmax: assert property (p_vmax) else $error("bad top step");
	// top bit wins
	// While switching, a new frequency waits for the period boundary,
	// which is up to one 1 MHz period of 250 cycles away.
	property p_freq;
		reg_wr && reg_addr == 8'h0E && reg_wdata[2]
			|-> ##[1:260] freq_sel_oh == 3'h4;
	endproperty
	a_freq: assert property (p_freq) else $error("bad freq");
	property p_load;
		reg_wr && reg_addr == 8'h08 && !reg_wdata[4]
			|-> ##[1:2] !active_load_en;
	endproperty
	a_load: assert property (p_load) else $error("load kept");
endmodule

bind bcc_ctrl bcc_ctrl_checker #(.SS_CYC(SS_CYC), .DUTY_PCT(DUTY_PCT)) u_chk (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .sw_gate(sw_gate), .vout_step(vout_step),
	.freq_sel_oh(freq_sel_oh), .pfm_mode(pfm_mode), .pwm_mode(pwm_mode),
	.active_load_en(active_load_en), .leds_blank(leds_blank));

// file: tb/bcc_ctrl_tb.sv
// Self-checking testbench for the boost control block.
`timescale 1ns/100ps
module bcc_ctrl_tb;
	localparam SS = 50;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg fb_low = 1'b0;
	reg ipk_trip = 1'b0;
	wire [7:0] reg_rdata;
	wire sw_gate, pfm_mode, pwm_mode, active_load_en, leds_blank;
	wire [3:0] vout_step;
	wire [2:0] freq_sel_oh;
	wire [1:0] rgb_sel;
	integer errors = 0;
	integer cmp_count = 0;
	integer cyc = 0;
	integer i, n;

	// Short soft start keeps the run brief.
	bcc_ctrl #(.SS_CYC(SS)) DUT (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fb_low_async(fb_low),
		.ipk_trip_async(ipk_trip), .sw_gate(sw_gate),
		.vout_step(vout_step), .freq_sel_oh(freq_sel_oh),
		.pfm_mode(pfm_mode), .pwm_mode(pwm_mode),
		.active_load_en(active_load_en), .leds_blank(leds_blank),
		.rgb_sel(rgb_sel));

	// Clock of 4 ns period.
	always #2 clk = ~clk;

	// A hang past the ceiling counts as a mismatch.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			results;
		end
	end

	task results;
		begin
			$display("checks %0d errors %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("ERROR %s exp %h got %h", nm, e, g);
			end
		end
	endtask

	// Writes are spaced so each settles before the next.
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			repeat (3) @(posedge clk);
			#1;
		end
	endtask

	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(posedge clk);
			#1;
			chk("rdata", e, reg_rdata);
		end
	endtask

	// Skips any pulse in flight, then times the next whole one.
	task pw(input [7:0] e);
		begin
			n = 0;
			while (sw_gate === 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			while (sw_gate !== 1'b1 && n < 600) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			n = 0;
			while (sw_gate === 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			chk("width", e, n[7:0]);
		end
	endtask

	// Times one switching period from one gate rise to the next.
	task per(input [7:0] e);
		begin
			n = 0;
			while (sw_gate !== 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			n = 0;
			while (sw_gate === 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			while (sw_gate !== 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			chk("period", e, n[7:0]);
		end
	endtask

	task t_reset;
		begin
			chk("vstep", 8'h06, 8'(vout_step));
			chk("fsel", 8'h04, 8'(freq_sel_oh));
			chk("gate", 8'h00, 8'(sw_gate));
			rd(8'h0D, 8'h3F);
			rd(8'h0E, 8'h07);
			rd(8'h08, 8'h00);
			$display("t_reset done");
		end
	endtask

	task t_vout;
		begin
			for (i = 0; i < 9; i = i + 1) begin
				wr(8'h0D, 8'hFF >> (8 - i));
				chk("vstep", i[7:0], 8'(vout_step));
			end
			for (i = 0; i < 8; i = i + 1) begin
				wr(8'h0D, 8'h01 << i);
				chk("vstep", i[7:0] + 8'h01, 8'(vout_step));
			end
			rd(8'h0D, 8'h80);
			$display("t_vout done");
		end
	endtask

	task t_freq;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				wr(8'h0E, i[7:0]);
				n = i[2] ? 4 : (i[1] ? 2 : 1);
				chk("fsel", n[7:0], 8'(freq_sel_oh));
			end
			rd(8'h0E, 8'h07);
			wr(8'h20, 8'h5A);
			rd(8'h20, 8'h00);
			$display("t_freq done");
		end
	endtask

	task t_boost;
		begin
			@(posedge clk);
			fb_low <= 1'b1;
			wr(8'h08, 8'hF0);
			chk("pfm", 8'h01, 8'(pfm_mode));
			chk("blank", 8'h01, 8'(leds_blank));
			chk("load", 8'h01, 8'(active_load_en));
			chk("rgb", 8'h03, 8'(rgb_sel));
			n = 0;
			while (pwm_mode !== 1'b1 && n < 200) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			chk("ss_len", 8'h01, 8'(n > SS - 4 && n < SS + 2));
			chk("blank", 8'h00, 8'(leds_blank));
			pw(8'h6A);
			per(8'h7D);
			wr(8'h0E, 8'h01);
			repeat (260) @(posedge clk);
			pw(8'hD4);
			wr(8'h0E, 8'h07);
			@(posedge clk);
			fb_low <= 1'b0;
			ipk_trip <= 1'b1;
			pw(8'h07);
			wr(8'h08, 8'h20);
			chk("load", 8'h00, 8'(active_load_en));
			// Load off and output high: pulses may now be skipped.
			n = 0;
			repeat (300) begin
				@(posedge clk);
				#1;
				n = n + (sw_gate !== 1'b0);
			end
			chk("skip", 8'h00, (n > 255) ? 8'hFF : n[7:0]);
			// The output sags again so pulses run when the disable lands.
			@(posedge clk);
			fb_low <= 1'b1;
			pw(8'h07);
			wr(8'h08, 8'h00);
			n = 0;
			repeat (300) begin
				@(posedge clk);
				#1;
				n = n + (sw_gate !== 1'b0);
			end
			chk("stop", 8'h00, (n > 255) ? 8'hFF : n[7:0]);
			chk("pwm", 8'h00, 8'(pwm_mode));
			$display("t_boost done");
		end
	endtask

	// Reset for two cycles, then the scenarios in turn.
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		t_reset;
		t_vout;
		t_freq;
		t_boost;
		results;
	end
endmodule
